// ===== rtl/guard_timer_map.vh
// register offsets, field positions, reset values and timing for guard_timer
// assumes an APB slave decoding byte addresses as word index times four
`ifndef GUARD_TIMER_MAP_VH
`define GUARD_TIMER_MAP_VH
// printed offsets are register indices, byte address is four times these
`define GT_IDX_CONTROL 8'h93
`define GT_IDX_RESTART 8'h94
`define GT_IDX_STATUS 8'h95
`define GT_IDX_MASK 8'h96
`define GT_IDX_RTCSEL 8'h97
// control fields
`define GT_BIT_EN 7
`define GT_BIT_NMI_OUT 6
`define GT_BIT_RST_FLAG 5
`define GT_BIT_NMI_FLAG 4
`define GT_CLK_HI 3
`define GT_CLK_LO 2
`define GT_PER_HI 1
`define GT_PER_LO 0
`define GT_CLK_RESET 2'h2
`define GT_SRC_SYS 2'h0
`define GT_SRC_RTC 2'h1
`define GT_SRC_RC 2'h2
// restart key pair
`define GT_KEY_FIRST 8'hA5
`define GT_KEY_SECOND 8'h5A
// status bits: 0 time-out interrupt, 1 foreign nmi seen, 2 key error
`define GT_STS_W 3
// oscillator start-up time in microseconds and clock period in ns
`define GT_RC_START_US 20000
`define GT_CLK_NS 4
`endif

// ===== rtl/guard_timer.v
// guard_timer: watchdog with selectable tick source, reset or nmi response
// assumes tick inputs are slow pins from other domains; apb on pclk
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "guard_timer_map.vh"
module guard_timer #(
    parameter RC_START_CYCLES = (`GT_RC_START_US * 1000 + `GT_CLK_NS - 1)
                                / `GT_CLK_NS
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire [31:0] prdata,
    output wire pslverr,
    // reset cause: high when this reset was raised by the watchdog itself
    input wire guard_reset_cause,
    // nmi from any other source, pulse or level on pclk
    input wire foreign_nmi,
    // tick sources from outside the pclk domain
    input wire rtc_tick_32k,
    input wire rtc_tick_mains,
    input wire rc_osc_tick,
    // response outputs
    output reg cpu_reset_req,
    output reg cpu_nmi,
    output reg rc_osc_power,
    output wire irq
);

    // control state
    // the control fields live in separate flops so the lock on enable
    // can gate them all at once; the two cause flags are read only and
    // only hardware moves them
    // the counter is wide enough for the longest system clock length,
    // so no source or period choice can wrap it before time-out
    reg en_q;
    reg nmi_out_q;
    reg rst_flag_q;
    reg nmi_flag_q;
    reg [1:0] clk_sel_q;
    reg [1:0] per_sel_q;
    reg rtc_mains_q;
    reg [27:0] cnt_q;
    reg key_armed_q;
    reg [`GT_STS_W-1:0] status_q;
    reg [`GT_STS_W-1:0] mask_q;
    reg [31:0] rdata_q;
    reg cause_seen_q;
    reg [22:0] rc_wait_q;
    // synchronisers and edge memories
    reg [2:0] sync1_q;
    reg [2:0] sync2_q;
    reg [2:0] prev_q;

    // apb decode
    // every register takes one aligned word; the index is the word number,
    // so the byte address is four times the index
    // a misaligned or unmapped address is answered with pslverr; an unmapped word reads 0, a misaligned read returns its aligned word
    // reads and writes only act in the access cycle; nothing in this block
    // reacts to the setup cycle except the read data capture below
    // the restart word is write only, so a read of it returns zero and
    // cannot leak the state of the key sequence
    wire wr = psel && penable && pwrite;
    wire rd = psel && penable && !pwrite;
    wire [9:0] idx = paddr[11:2];
    wire addr_ok = (paddr[1:0] == 2'h0) &&
                   ((idx == {2'h0, `GT_IDX_CONTROL}) ||
                    (idx == {2'h0, `GT_IDX_RESTART}) ||
                    (idx == {2'h0, `GT_IDX_STATUS}) ||
                    (idx == {2'h0, `GT_IDX_MASK}) ||
                    (idx == {2'h0, `GT_IDX_RTCSEL}));

    // time-out length in ticks for a source and period code
    // the lengths are powers of two, so only the shift is decoded; the
    // reserved source falls into the rc row but never ticks, so its length
    // is never reached
    // keeping this in one place means the compare below stays a single term
    function [27:0] limit;
        input [1:0] src;
        input [1:0] per;
        reg [4:0] sh;
        begin
            sh = 5'h0;
            case (src)
                `GT_SRC_SYS: begin
                    case (per)
                        2'h0: sh = 5'h1B;
                        2'h1: sh = 5'h19;
                        2'h2: sh = 5'h16;
                        default: sh = 5'h12;
                    endcase
                end
                `GT_SRC_RTC: begin
                    case (per)
                        2'h0: sh = 5'h11;
                        2'h1: sh = 5'h0E;
                        2'h2: sh = 5'h0B;
                        default: sh = 5'h07;
                    endcase
                end
                default: begin
                    case (per)
                        2'h0: sh = 5'h0F;
                        2'h1: sh = 5'h0D;
                        2'h2: sh = 5'h09;
                        default: sh = 5'h05;
                    endcase
                end
            endcase
            limit = 28'h1 << sh;
        end
    endfunction

    // apb answers in the access cycle; all mapped words, unmapped errors
    // zero wait states: every register is a flop, so nothing needs a stall
    // pslverr stands only in the access cycle, never in setup, so a master
    // that samples it with pready sees a clean answer
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign prdata = rdata_q;

    wire [7:0] ctrl_view = {en_q, nmi_out_q, rst_flag_q, nmi_flag_q,
                            clk_sel_q, per_sel_q};

    // read data register, updated during setup so it is stable in access
    // loading it one cycle early keeps prdata a flop output while still
    // answering with zero wait states
    // a flag that moves between setup and access shows its setup value,
    // which is the value at the start of the transfer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr[11:2])
                {2'h0, `GT_IDX_CONTROL}: rdata_q <= {24'h0, ctrl_view};
                {2'h0, `GT_IDX_STATUS}: rdata_q <= {29'h0, status_q};
                {2'h0, `GT_IDX_MASK}: rdata_q <= {29'h0, mask_q};
                {2'h0, `GT_IDX_RTCSEL}: rdata_q <= {31'h0, rtc_mains_q};
                default: rdata_q <= 32'h0;
            endcase
        end
    end

    // tick inputs cross in through two flops before anything looks at them
    // the slow sources are free running square waves from other domains;
    // only the second flop feeds logic, so a metastable first stage has a
    // whole cycle to settle
    // the edge memory resets low, like the pins' idle level, so a pin that is
    // already high at release of reset reads as one rising edge
    // limitation: a tick source faster than half of pclk loses edges
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            prev_q <= 3'h0;
        end else begin
            sync1_q <= {rc_osc_tick, rtc_tick_mains, rtc_tick_32k};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end
    wire [2:0] rise = sync2_q & ~prev_q;

    // tick selection
    // the system clock ticks on every pclk edge; the rtc and rc sources tick
    // once per synchronised rising edge
    // the reserved source code never ticks, so a watchdog enabled with it
    // stands still rather than counting an undefined clock
    // rtc tick follows rtc control choice
    wire rtc_tick = rtc_mains_q ? rise[1] : rise[0];
    // rc ticks ignored until start-up time has passed
    wire rc_ready = (rc_wait_q == 23'h0);
    reg tick;
    always @* begin
        case (clk_sel_q)
            `GT_SRC_SYS: tick = 1'b1;
            `GT_SRC_RTC: tick = rtc_tick;
            `GT_SRC_RC: tick = rise[2] && rc_ready;
            default: tick = 1'b0;
        endcase
    end

    // time-out detection
    // the count runs from zero, so the time-out tick is the one that would
    // take it to the full length; comparing with length minus one lets the
    // reload happen on that same tick
    // the restart key only acts on the restart word, never on control
    // time-out when count reaches the selected length
    wire timeout = en_q && tick &&
                   (cnt_q == limit(clk_sel_q, per_sel_q) - 28'h1);
    wire ctl_wr = wr && idx == {2'h0, `GT_IDX_CONTROL} && addr_ok;
    wire rr_wr = wr && idx == {2'h0, `GT_IDX_RESTART} && addr_ok;
    // key pair completes on 5Ah after an armed A5h
    wire restart = rr_wr && key_armed_q && pwdata[7:0] == `GT_KEY_SECOND;
    wire key_err = rr_wr && key_armed_q && pwdata[7:0] != `GT_KEY_SECOND;

    // control register
    // once enable is set the whole word is frozen, not only the enable bit,
    // so runaway code cannot shorten or redirect a running watchdog
    // the rtc tick choice lives in its own word and stays writable; it
    // belongs to the rtc, not to the watchdog lock
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 1'b0;
            nmi_out_q <= 1'b0;
            clk_sel_q <= `GT_CLK_RESET;
            per_sel_q <= 2'h0;
            rtc_mains_q <= 1'b0;
        end else begin
            if (ctl_wr && !en_q) begin
                en_q <= pwdata[`GT_BIT_EN];
                nmi_out_q <= pwdata[`GT_BIT_NMI_OUT];
                clk_sel_q <= pwdata[`GT_CLK_HI:`GT_CLK_LO];
                per_sel_q <= pwdata[`GT_PER_HI:`GT_PER_LO];
            end
            if (wr && idx == {2'h0, `GT_IDX_RTCSEL} && addr_ok) begin
                rtc_mains_q <= pwdata[0];
            end
        end
    end

    // counter and restart key sequence
    // the key arms only on the first value and fires only on the second,
    // with any number of cycles between them
    // a wrong second value, or the first value again, leaves the key
    // disarmed, so a stuck loop writing one value can never restart it
    // the counter is held at zero while disabled, so enabling always starts
    // a full length
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 28'h0;
            key_armed_q <= 1'b0;
        end else begin
            if (rr_wr) begin
                key_armed_q <= !key_armed_q &&
                               pwdata[7:0] == `GT_KEY_FIRST;
                if (key_armed_q && pwdata[7:0] == `GT_KEY_FIRST &&
                    !restart) begin
                    key_armed_q <= 1'b0;
                end
            end
            // reload after a time-out and keep running
            if (restart || timeout || !en_q) begin
                cnt_q <= 28'h0;
            end else if (tick) begin
                cnt_q <= cnt_q + 28'h1;
            end
        end
    end

    // rc oscillator power and start-up wait
    // the oscillator runs only while it is the chosen source, which saves
    // its power when another source counts
    // after a power-up from another source its first edges are unreliable, so its ticks are
    // ignored until the start-up count has run out
    // trade-off: the wait lengthens the first time-out a little rather
    // than risk an early one from a glitching oscillator
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rc_osc_power <= 1'b1;
            rc_wait_q <= 23'h0;
        end else begin
            // power down only when another source is selected
            rc_osc_power <= (clk_sel_q == `GT_SRC_RC);
            // restart the wait on every power-up after another source; reset leaves it at zero
            if (clk_sel_q != `GT_SRC_RC) begin
                rc_wait_q <= RC_START_CYCLES[22:0];
            end else if (rc_wait_q != 23'h0) begin
                rc_wait_q <= rc_wait_q - 23'h1;
            end
        end
    end

    // response outputs and cause flags
    // the reset request stays high until reset arrives, because the cpu
    // may only act on it a few cycles later
    // the reset flag is loaded once from the reset cause on the first edge
    // after release, so only a watchdog reset leaves it set
    // the nmi is a single cycle pulse; the cpu latches its own nmi edge
    // an own time-out in the same cycle as a foreign nmi keeps the flag set
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_reset_req <= 1'b0;
            cpu_nmi <= 1'b0;
            nmi_flag_q <= 1'b0;
            rst_flag_q <= 1'b0;
            cause_seen_q <= 1'b0;
        end else begin
            // reset cause caught once after release
            cause_seen_q <= 1'b1;
            if (!cause_seen_q) begin
                rst_flag_q <= guard_reset_cause;
            end
            if (timeout && !nmi_out_q) begin
                cpu_reset_req <= 1'b1;
                rst_flag_q <= 1'b1;
            end
            cpu_nmi <= timeout && nmi_out_q;
            // own time-out wins over a foreign nmi
            if (timeout && nmi_out_q) begin
                nmi_flag_q <= 1'b1;
            end else if (foreign_nmi) begin
                nmi_flag_q <= 1'b0;
            end
        end
    end

    // sticky status, set wins over write-one-to-clear
    // an event that lands in the cycle of a clear write must not be lost,
    // so the set term is applied after the clear
    // the mask only gates the interrupt; status bits set whatever it holds
    wire [`GT_STS_W-1:0] sts_set = {key_err, foreign_nmi,
                                    timeout && nmi_out_q};
    wire sts_wr = wr && idx == {2'h0, `GT_IDX_STATUS} && addr_ok;
    wire [`GT_STS_W-1:0] sts_clr = sts_wr ? pwdata[`GT_STS_W-1:0] :
                                   {`GT_STS_W{1'b0}};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= {`GT_STS_W{1'b0}};
            mask_q <= {`GT_STS_W{1'b0}};
        end else begin
            status_q <= (status_q & ~sts_clr) | sts_set;
            if (wr && idx == {2'h0, `GT_IDX_MASK} && addr_ok) begin
                mask_q <= pwdata[`GT_STS_W-1:0];
            end
        end
    end
    // level interrupt while any enabled status bit is set
    // combinational from flops, so it follows a clear in the same cycle
    // that the status flop drops
    assign irq = |(status_q & mask_q);

endmodule

// ===== verif/guard_checks_properties.sv
// checker on guard_timer ports, bound into every instance
// assumes apb byte addresses and pclk as the only clock
`timescale 1ns/1ps
module guard_checks #(
    parameter RC_START_CYCLES = 10
) (
    // clock, reset, apb
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] prdata,
    input logic pslverr,
    // events and responses
    input logic foreign_nmi,
    input logic cpu_reset_req,
    input logic cpu_nmi,
    input logic rc_osc_power,
    input logic irq
);
    // apb write in its access cycle, and one aimed at control
    wire wr = psel && penable && pwrite;
    wire ctl_wr = wr && paddr == 12'h24C;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_quiet; $rose(presetn) |-> !cpu_nmi; endproperty
    a_quiet: assert property (p_quiet) else $error("nmi at release");
    property p_hold; cpu_reset_req |=> cpu_reset_req; endproperty
    a_hold: assert property (p_hold) else $error("reset dropped");
    property p_excl; cpu_reset_req |-> !cpu_nmi; endproperty
    a_excl: assert property (p_excl) else $error("nmi in reset");
    property p_gap; cpu_nmi |=> !cpu_nmi [*8]; endproperty
    a_gap: assert property (p_gap) else $error("nmi too close");
    // source change follows a control write by one or two cycles
    property p_pwr;
        $changed(rc_osc_power) |-> $past(ctl_wr) || $past(ctl_wr, 2);
    endproperty
    a_pwr: assert property (p_pwr) else $error("rc power moved");
    property p_err; pslverr |-> psel && penable; endproperty
    a_err: assert property (p_err) else $error("stray pslverr");
    property p_wo;
        psel && penable && !pwrite && paddr == 12'h250 |-> prdata == 0;
    endproperty
    a_wo: assert property (p_wo) else $error("restart readable");
    property p_irq;
        $rose(irq) |-> cpu_nmi || $past(cpu_nmi || foreign_nmi || wr);
    endproperty
    a_irq: assert property (p_irq) else $error("irq no cause");
endmodule
bind guard_timer guard_checks #(.RC_START_CYCLES(RC_START_CYCLES))
    guard_checks_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pslverr(pslverr), .foreign_nmi(foreign_nmi),
    .cpu_reset_req(cpu_reset_req), .cpu_nmi(cpu_nmi),
    .rc_osc_power(rc_osc_power), .irq(irq));

// ===== verif/tick_src.sv
// stand-in tick sources for the slow oscillator pins
// assumes pclk runs free; ticks come from a pclk count
`timescale 1ns/1ps
module tick_src (
    // clock and rc oscillator power
    input wire pclk,
    input wire rc_osc_power,
    // square wave ticks
    output reg rtc_tick_32k = 1'b0,
    output reg rtc_tick_mains = 1'b0,
    output reg rc_osc_tick = 1'b0
);
    integer n = 0;
    // rc stands still while unpowered, as the real oscillator would
    always @(posedge pclk) begin
        n <= n + 1;
        rtc_tick_32k <= n[2];
        rtc_tick_mains <= n[1];
        rc_osc_tick <= rc_osc_power & n[2];
    end
endmodule

// ===== verif/tb_top.sv
// bench for guard_timer: apb task and scripted register sequences
// assumes tick_src drives the slow tick pins
`timescale 1ns/1ps
`include "guard_timer_map.vh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    n_errors++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top;
    reg pclk, presetn, psel, penable, pwrite, guard_reset_cause;
    reg foreign_nmi, se;
    reg [11:0] paddr;
    reg [31:0] pwdata, rd;
    wire pready, pslverr, cpu_reset_req, cpu_nmi, rc_osc_power, irq;
    wire rtc_tick_32k, rtc_tick_mains, rc_osc_tick;
    wire [31:0] prdata;
    integer n_errors = 0, comparisons = 0, cyc = 0, i;
    localparam [7:0] ctl = `GT_IDX_CONTROL, sts = `GT_IDX_STATUS;
    localparam [7:0] key = `GT_IDX_RESTART, msk = `GT_IDX_MASK;
    localparam [7:0] rsel = `GT_IDX_RTCSEL;
    // 4 ns period
    always #2 pclk = ~pclk;
    guard_timer #(.RC_START_CYCLES(10)) guard_timer_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr),
        .guard_reset_cause(guard_reset_cause), .foreign_nmi(foreign_nmi),
        .rtc_tick_32k(rtc_tick_32k), .rtc_tick_mains(rtc_tick_mains),
        .rc_osc_tick(rc_osc_tick), .cpu_reset_req(cpu_reset_req),
        .cpu_nmi(cpu_nmi), .rc_osc_power(rc_osc_power), .irq(irq));
    tick_src tick_src_i (.pclk(pclk), .rc_osc_power(rc_osc_power),
        .rtc_tick_32k(rtc_tick_32k), .rtc_tick_mains(rtc_tick_mains),
        .rc_osc_tick(rc_osc_tick));
    // apb transfer; answer taken at the edge where pready is sampled high
    task xf(input w, input [7:0] idx, input [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, 2'h0, idx, 2'h0, d};
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {rd, se} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
        if (!w) `CHK("read", d, rd)
    endtask
    // wait on negedges for a time-out response, lim cycles at most
    task wn(input integer lim);
        i = 0;
        while (!cpu_nmi && !cpu_reset_req && i < lim) @(negedge pclk) i++;
    endtask
    task rst(input c);
        @(posedge pclk) {presetn, guard_reset_cause} <= {1'b0, c};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task wrap_up;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // the script needs about 1850 cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            n_errors++;
            wrap_up;
        end
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite, guard_reset_cause} = 6'h00;
        {foreign_nmi, paddr, pwdata} = 45'h0;
        rst(1'b0);
        // reset state, then an unmapped read
        xf(1'b0, ctl, 32'h08);
        `CHK("slverr", 1'b0, se)
        `CHK("rc power", 1'b1, rc_osc_power)
        xf(1'b0, 8'h10, 32'h0);
        `CHK("slverr", 1'b1, se)
        xf(1'b0, key, 32'h0);
        // rc source, shortest period, nmi response; later write ignored
        xf(1'b1, msk, 32'h1);
        xf(1'b1, ctl, 32'hCB);
        xf(1'b1, ctl, 32'h0);
        xf(1'b0, ctl, 32'hCB);
        wn(400);
        `CHK("nmi", 1'b1, cpu_nmi)
        `CHK("rc period", 1'b1, i > 230 && i < 280)
        xf(1'b0, sts, 32'h1);
        `CHK("irq", 1'b1, irq)
        xf(1'b0, ctl, 32'hDB);
        xf(1'b1, sts, 32'h1);
        @(negedge pclk) `CHK("irq", 1'b0, irq)
        // count reloads, then a foreign nmi clears the flag
        wn(400);
        `CHK("nmi", 1'b1, cpu_nmi)
        @(posedge pclk) foreign_nmi <= 1'b1;
        @(posedge pclk) foreign_nmi <= 1'b0;
        xf(1'b0, ctl, 32'hCB);
        xf(1'b0, sts, 32'h3);
        // good pair delays the time-out, a broken pair does not
        repeat (150) @(posedge pclk);
        xf(1'b1, key, 32'hA5);
        xf(1'b1, key, 32'h5A);
        wn(200);
        `CHK("nmi", 1'b0, cpu_nmi)
        xf(1'b1, key, 32'hA5);
        xf(1'b1, key, 32'h11);
        wn(120);
        `CHK("nmi", 1'b1, cpu_nmi)
        xf(1'b0, sts, 32'h7);
        // mains tick, shortest period, reset response
        rst(1'b0);
        xf(1'b1, rsel, 32'h1);
        xf(1'b1, ctl, 32'h87);
        wn(800);
        `CHK("reset", 1'b1, cpu_reset_req)
        `CHK("rtc period", 1'b1, i > 470 && i < 560)
        `CHK("rc power", 1'b0, rc_osc_power)
        // flag kept by its own reset, cleared by any other
        rst(1'b1);
        xf(1'b0, ctl, 32'h28);
        rst(1'b0);
        xf(1'b0, ctl, 32'h08);
        // system clock, shortest length: far beyond a short wait
        xf(1'b1, ctl, 32'hC3);
        wn(300);
        `CHK("sys early", 1'b0, cpu_nmi | cpu_reset_req)
        `CHK("rc power", 1'b0, rc_osc_power)
        wrap_up;
    end
endmodule
